// [core/sbm_unit.sv]
// Shift and bit manipulation unit: byte shifts and rotates on a register
// operand, and single-bit operations on a register or memory byte.
// Assumes the decoder presents one request per start pulse and waits for
// done; register file values are supplied with the request.
import sbm_pkg::*;

module sbm_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the decoder
  input wire logic start,
  input wire sbm_pkg::sbm_op_t op,
  input wire logic [15:0] instr,
  input wire logic use_iw,
  input wire logic [3:0] reg_sel,
  input wire logic [7:0] reg_data,
  input wire logic mem_opnd,
  input wire logic [15:0] mem_addr_in,
  input wire logic bitno_from_reg,
  input wire logic [2:0] bitno_imm,
  input wire logic [7:0] bitno_reg,
  input wire logic c_in,
  // Results
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] result,
  output logic reg_we,
  output logic [3:0] reg_wsel,
  output logic c_we,
  output logic c_out,
  output logic z_we,
  output logic z_out,
  // Memory
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  import sbm_pkg::*;

  typedef enum logic [3:0] {
    SBM_IDLE = 4'h1,
    SBM_READ = 4'h2,
    SBM_WRITE = 4'h4,
    SBM_DONE = 4'h8
  } sbm_state_t;

  typedef struct packed {
    // Sequencer
    sbm_state_t state;
    // Request captured at start
    sbm_op_t op;
    logic [2:0] bit_no;
    logic [7:0] opnd;
    logic [3:0] rsel;
    logic [15:0] addr;
    logic c;
    logic mem;
    // Registered outputs
    logic [7:0] result;
    logic reg_we;
    logic c_we;
    logic c_val;
    logic z_we;
    logic z_val;
    logic done;
    logic illegal;
  } sbm_st_t;

  sbm_st_t st_r;
  sbm_st_t st_nxt;

  sbm_mem_if mif ();

  logic [7:0] bo_res;
  logic bo_c;
  logic bo_z;
  logic bo_wb;
  logic bo_wc;
  logic bo_wz;
  logic [7:0] bo_opnd;

  // Maps a shift instruction word's opcode field onto an operation code
  function automatic sbm_op_t sbm_decode_shift(input logic [11:0] opc);
    case (opc)
      SBM_OPC_ASL: sbm_decode_shift = SBM_OP_ARITH_SHIFT_LEFT;
      SBM_OPC_ASR: sbm_decode_shift = SBM_OP_ARITH_SHIFT_RIGHT;
      SBM_OPC_LSL: sbm_decode_shift = SBM_OP_LOGIC_SHIFT_LEFT;
      SBM_OPC_LSR: sbm_decode_shift = SBM_OP_LOGIC_SHIFT_RIGHT;
      SBM_OPC_RL: sbm_decode_shift = SBM_OP_ROTATE_LEFT_PLAIN;
      SBM_OPC_RR: sbm_decode_shift = SBM_OP_ROTATE_RIGHT_PLAIN;
      SBM_OPC_RLC: sbm_decode_shift = SBM_OP_ROTATE_LEFT_VIA_CARRY;
      SBM_OPC_RRC: sbm_decode_shift = SBM_OP_ROTATE_RIGHT_VIA_CARRY;
      default: sbm_decode_shift = SBM_OP_NONE;
    endcase
  endfunction

  // Shift group operations never take a memory operand
  function automatic logic sbm_is_shift(input sbm_op_t o);
    sbm_is_shift = (o >= SBM_OP_ARITH_SHIFT_LEFT) &&
                   (o <= SBM_OP_ROTATE_RIGHT_VIA_CARRY);
  endfunction

  // Inverted-bit carry operations accept an immediate bit number only
  function automatic logic sbm_is_inv_carry(input sbm_op_t o);
    sbm_is_inv_carry = (o == SBM_OP_CARRY_AND_INVERTED_BIT) ||
                       (o == SBM_OP_CARRY_OR_INVERTED_BIT);
  endfunction

  // A freshly read memory byte is modified before the write strobe rises
  assign bo_opnd = (st_r.state == SBM_READ) ? mif.rdata : st_r.opnd;

  sbm_bitop u_bitop (
    .op(st_r.op),
    .bit_no(st_r.bit_no),
    .opnd(bo_opnd),
    .c_in(st_r.c),
    .res(bo_res),
    .c_out(bo_c),
    .z_out(bo_z),
    .writes_byte(bo_wb),
    .writes_c(bo_wc),
    .writes_z(bo_wz)
  );

  sbm_mem_port u_mem_port (
    .clk(clk),
    .rst_n(rst_n),
    .mif(mif),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  // Memory handshake towards the port
  assign mif.rd_req = (st_r.state == SBM_READ);
  // Only byte-changing memory operations write; probe and carry ops
  // leave the byte alone
  assign mif.wr_req = (st_r.state == SBM_WRITE) && st_r.mem && bo_wb;
  assign mif.addr = st_r.addr;
  assign mif.wdata = st_r.result;

  always_comb begin
    sbm_op_t new_op;
    logic [7:0] v;
    logic cin;
    new_op = SBM_OP_NONE;
    v = st_r.opnd;
    cin = st_r.c;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.reg_we = 1'b0;
    st_nxt.c_we = 1'b0;
    st_nxt.z_we = 1'b0;

    case (st_r.state)
      SBM_IDLE: begin
        if (start) begin
          // Shift word: opcode above, one register field for source and
          // destination
          if (use_iw) begin
            new_op = sbm_decode_shift(instr[SBM_OPC_LSB +: SBM_OPC_W]);
            st_nxt.rsel = instr[SBM_REG_FIELD_LSB +: SBM_REG_FIELD_W];
          end else begin
            new_op = op;
            st_nxt.rsel = reg_sel;
          end
          st_nxt.op = new_op;

          st_nxt.opnd = reg_data;
          st_nxt.c = c_in;
          st_nxt.addr = mem_addr_in;
          st_nxt.mem = mem_opnd & ~sbm_is_shift(new_op);

          if (bitno_from_reg && !sbm_is_inv_carry(new_op)) begin
            st_nxt.bit_no = bitno_reg[SBM_BITNO_W-1:0];
          end else begin
            st_nxt.bit_no = bitno_imm;
          end

          // Register bit number on an immediate-only operation is refused
          st_nxt.illegal = (new_op == SBM_OP_NONE) ||
            (bitno_from_reg && sbm_is_inv_carry(new_op));
          if (st_nxt.illegal) begin
            st_nxt.state = SBM_DONE;
          end else if (st_nxt.mem) begin
            st_nxt.state = SBM_READ;
          end else begin
            st_nxt.state = SBM_WRITE;
          end
        end
      end

      SBM_READ: begin
        if (mif.rd_done) begin
          st_nxt.opnd = mif.rdata;
          st_nxt.result = bo_res;
          st_nxt.state = SBM_WRITE;
        end
      end

      SBM_WRITE: begin
        if (sbm_is_shift(st_r.op)) begin
          st_nxt.c_we = 1'b1;
          st_nxt.reg_we = 1'b1;
          // Shift group: the bit moved out of the byte lands in carry
          case (st_r.op)
            SBM_OP_ARITH_SHIFT_LEFT: begin
              st_nxt.result = {v[6:0], 1'b0};
              st_nxt.c_val = v[7];
            end

            SBM_OP_ARITH_SHIFT_RIGHT: begin
              st_nxt.result = {v[7], v[7:1]};
              st_nxt.c_val = v[0];
            end

            SBM_OP_LOGIC_SHIFT_LEFT: begin
              st_nxt.result = {v[6:0], 1'b0};
              st_nxt.c_val = v[7];
            end

            SBM_OP_LOGIC_SHIFT_RIGHT: begin
              st_nxt.result = {1'b0, v[7:1]};
              st_nxt.c_val = v[0];
            end

            SBM_OP_ROTATE_LEFT_PLAIN: begin
              st_nxt.result = {v[6:0], v[7]};
              st_nxt.c_val = v[7];
            end

            SBM_OP_ROTATE_RIGHT_PLAIN: begin
              st_nxt.result = {v[0], v[7:1]};
              st_nxt.c_val = v[0];
            end

            SBM_OP_ROTATE_LEFT_VIA_CARRY: begin
              st_nxt.result = {v[6:0], cin};
              st_nxt.c_val = v[7];
            end

            SBM_OP_ROTATE_RIGHT_VIA_CARRY: begin
              st_nxt.result = {cin, v[7:1]};
              st_nxt.c_val = v[0];
            end
            default: begin
              st_nxt.result = v;
            end
          endcase
          st_nxt.state = SBM_DONE;
        end else begin
          // Bit operations: modified byte, carry or zero flag
          st_nxt.result = bo_res;
          st_nxt.c_val = bo_c;
          st_nxt.z_val = bo_z;
          st_nxt.c_we = bo_wc;
          st_nxt.z_we = bo_wz;
          if (st_r.mem && bo_wb) begin
            // Whole byte goes back to the address it came from
            if (mif.wr_done) begin
              st_nxt.state = SBM_DONE;
            end
            st_nxt.c_we = 1'b0;
            st_nxt.z_we = 1'b0;
          end else begin
            st_nxt.reg_we = bo_wb & ~st_r.mem;
            st_nxt.state = SBM_DONE;
          end
        end
      end

      SBM_DONE: begin
        st_nxt.done = 1'b1;
        st_nxt.state = SBM_IDLE;
      end

      default: begin
        st_nxt.state = SBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '{
        state: SBM_IDLE,
        op: SBM_OP_NONE,
        bit_no: 3'h0,
        opnd: SBM_BYTE_RST,
        rsel: 4'h0,
        addr: SBM_ADDR_RST,
        c: 1'b0,
        mem: 1'b0,
        result: SBM_BYTE_RST,
        reg_we: 1'b0,
        c_we: 1'b0,
        c_val: 1'b0,
        z_we: 1'b0,
        z_val: 1'b0,
        done: 1'b0,
        illegal: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign busy = (st_r.state != SBM_IDLE);
  assign done = st_r.done;
  assign illegal = st_r.illegal;
  assign result = st_r.result;
  assign reg_we = st_r.reg_we;
  assign reg_wsel = st_r.rsel;
  assign c_we = st_r.c_we;
  assign c_out = st_r.c_val;
  assign z_we = st_r.z_we;
  assign z_out = st_r.z_val;
endmodule : sbm_unit

// [core/sbm_pkg.sv]
// Package for the shift and bit manipulation unit: operation codes and
// instruction word layout.
// Assumes a decoder that maps instruction words onto these codes.
package sbm_pkg;
  localparam int unsigned SBM_OP_W = 5;
  typedef enum logic [SBM_OP_W-1:0] {
    SBM_OP_NONE = 5'h00,
    SBM_OP_ARITH_SHIFT_LEFT = 5'h01,
    SBM_OP_ARITH_SHIFT_RIGHT = 5'h02,
    SBM_OP_LOGIC_SHIFT_LEFT = 5'h03,
    SBM_OP_LOGIC_SHIFT_RIGHT = 5'h04,
    SBM_OP_ROTATE_LEFT_PLAIN = 5'h05,
    SBM_OP_ROTATE_RIGHT_PLAIN = 5'h06,
    SBM_OP_ROTATE_LEFT_VIA_CARRY = 5'h07,
    SBM_OP_ROTATE_RIGHT_VIA_CARRY = 5'h08,
    SBM_OP_SINGLE_BIT_FORCE_ONE = 5'h09,
    SBM_OP_SINGLE_BIT_FORCE_ZERO = 5'h0A,
    SBM_OP_SINGLE_BIT_INVERT = 5'h0B,
    SBM_OP_SINGLE_BIT_PROBE = 5'h0C,
    SBM_OP_CARRY_AND_BIT = 5'h0D,
    SBM_OP_CARRY_AND_INVERTED_BIT = 5'h0E,
    SBM_OP_CARRY_OR_BIT = 5'h0F,
    SBM_OP_CARRY_OR_INVERTED_BIT = 5'h10,
    SBM_OP_CARRY_XOR_BIT = 5'h11
  } sbm_op_t;

  // Instruction word: operation field above, register_field in bits 3:0
  localparam int unsigned SBM_IW_W = 16;
  localparam int unsigned SBM_REG_FIELD_LSB = 0;
  localparam int unsigned SBM_REG_FIELD_W = 4;
  localparam int unsigned SBM_OPC_LSB = 4;
  localparam int unsigned SBM_OPC_W = 12;
  localparam int unsigned SBM_BITNO_W = 3;

  // Shift group operation codes in the upper 12 bits (plain defaults)
  localparam logic [11:0] SBM_OPC_ASL = 12'h108;
  localparam logic [11:0] SBM_OPC_ASR = 12'h118;
  localparam logic [11:0] SBM_OPC_LSL = 12'h100;
  localparam logic [11:0] SBM_OPC_LSR = 12'h110;
  localparam logic [11:0] SBM_OPC_RL = 12'h128;
  localparam logic [11:0] SBM_OPC_RR = 12'h138;
  localparam logic [11:0] SBM_OPC_RLC = 12'h120;
  localparam logic [11:0] SBM_OPC_RRC = 12'h130;

  localparam logic [7:0] SBM_BYTE_RST = 8'h00;
  localparam logic [15:0] SBM_ADDR_RST = 16'h0000;
endpackage : sbm_pkg

// [core/sbm_mem_if.sv]
// Interface carrying the memory read-modify-write handshake between the
// unit's sequencer and its memory port.
// Assumes a single clock shared by both ends.
interface sbm_mem_if;
  logic rd_req;
  logic wr_req;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_done;
  logic wr_done;
  modport seq (output rd_req, output wr_req, output addr, output wdata,
               input rdata, input rd_done, input wr_done);
  modport port (input rd_req, input wr_req, input addr, input wdata,
                output rdata, output rd_done, output wr_done);
endinterface : sbm_mem_if

// [core/sbm_mem_port.sv]
// Memory port: passes the sequencer's strobes to the bus and registers the
// data read back.
// Assumes memory answers a strobe with a one-cycle ack, any latency.
module sbm_mem_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer side
  sbm_mem_if.port mif,
  // Memory side
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  import sbm_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic rd_done;
    logic wr_done;
  } sbm_port_st_t;

  sbm_port_st_t st_r;
  sbm_port_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_done = mif.rd_req & mem_ack;
    st_nxt.wr_done = mif.wr_req & mem_ack;
    if (mif.rd_req && mem_ack) begin
      st_nxt.rdata = mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '{rdata: SBM_BYTE_RST, rd_done: 1'b0, wr_done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem_rd = mif.rd_req & ~st_r.rd_done;
  assign mem_wr = mif.wr_req & ~st_r.wr_done;
  assign mem_addr = mif.addr;
  assign mem_wdata = mif.wdata;
  assign mif.rdata = st_r.rdata;
  assign mif.rd_done = st_r.rd_done;
  assign mif.wr_done = st_r.wr_done;
endmodule : sbm_mem_port

// [core/sbm_bitop.sv]
// Bit operation datapath: selected-bit modify of a byte and carry logic.
// Purely combinational; assumes op and bit number are stable while used.
module sbm_bitop (
  // Operation
  input wire sbm_pkg::sbm_op_t op,
  input wire logic [2:0] bit_no,
  // Operand and flags in
  input wire logic [7:0] opnd,
  input wire logic c_in,
  // Results
  output logic [7:0] res,
  output logic c_out,
  output logic z_out,
  output logic writes_byte,
  output logic writes_c,
  output logic writes_z
);
  import sbm_pkg::*;

  logic [7:0] mask;
  logic sel;

  assign mask = 8'h01 << bit_no;
  assign sel = opnd[bit_no];

  always_comb begin
    res = opnd;
    c_out = c_in;
    z_out = 1'b0;
    writes_byte = 1'b0;
    writes_c = 1'b0;
    writes_z = 1'b0;
    case (op)
      SBM_OP_SINGLE_BIT_FORCE_ONE: begin
        res = opnd | mask;
        writes_byte = 1'b1;
      end
      SBM_OP_SINGLE_BIT_FORCE_ZERO: begin
        res = opnd & ~mask;
        writes_byte = 1'b1;
      end
      SBM_OP_SINGLE_BIT_INVERT: begin
        res = opnd ^ mask;
        writes_byte = 1'b1;
      end
      SBM_OP_SINGLE_BIT_PROBE: begin
        z_out = ~sel;
        writes_z = 1'b1;
      end
      SBM_OP_CARRY_AND_BIT: begin
        c_out = c_in & sel;
        writes_c = 1'b1;
      end
      SBM_OP_CARRY_AND_INVERTED_BIT: begin
        c_out = c_in & ~sel;
        writes_c = 1'b1;
      end
      SBM_OP_CARRY_OR_BIT: begin
        c_out = c_in | sel;
        writes_c = 1'b1;
      end
      SBM_OP_CARRY_OR_INVERTED_BIT: begin
        c_out = c_in | ~sel;
        writes_c = 1'b1;
      end
      SBM_OP_CARRY_XOR_BIT: begin
        c_out = c_in ^ sel;
        writes_c = 1'b1;
      end
      default: begin
        res = opnd;
      end
    endcase
  end
endmodule : sbm_bitop

// [test/sbm_mem_model.sv]
// Memory model at the unit's far side: a byte store that answers each
// strobe with a one-cycle ack after a wait set by the bench.
// Assumes strobes are held until ack, as the unit's port promises.
module sbm_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wait before ack, in cycles
  input wire logic [3:0] lat,
  // Memory bus
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [256];
  logic [7:0] rd_q;
  logic [3:0] cnt;
  int wr_n = 0;
  // Outside the ack cycle the data lines show junk, not the last byte
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (!rst_n) begin
      cnt <= 4'h0;
      rd_q <= 8'h00;
    end else if ((mem_rd || mem_wr) && !mem_ack) begin
      if (cnt >= lat) begin
        mem_ack <= 1'b1;
        cnt <= 4'h0;
        if (mem_wr) begin
          mem[mem_addr[7:0]] <= mem_wdata;
          wr_n <= wr_n + 1;
        end else begin
          rd_q <= mem[mem_addr[7:0]];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // sbm_mem_model

// [test/sbm_unit_checker.sv]
// Checker for the shift and bit manipulation unit, bound to its top.
// Assumes one clock and a synchronous active-low reset.
module sbm_unit_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire sbm_pkg::sbm_op_t op,
  input wire logic use_iw,
  input wire logic [3:0] reg_sel,
  input wire logic [7:0] reg_data,
  input wire logic mem_opnd,
  input wire logic bitno_from_reg,
  input wire logic [2:0] bitno_imm,
  input wire logic [7:0] bitno_reg,
  input wire logic c_in,
  // Results
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic [7:0] result,
  input wire logic reg_we,
  input wire logic [3:0] reg_wsel,
  input wire logic c_we,
  input wire logic c_out,
  input wire logic z_we,
  input wire logic z_out,
  input wire logic mem_rd,
  input wire logic mem_ack
);
  import sbm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] sel;
  logic sv, go, rg;
  logic [7:0] d1, d2;
  assign sel = bitno_from_reg ? bitno_reg[2:0] : bitno_imm;
  assign sv = reg_data[sel];
  assign go = start && !busy && !use_iw && !mem_opnd;
  assign rg = go && op inside {[SBM_OP_ARITH_SHIFT_LEFT:
    SBM_OP_SINGLE_BIT_INVERT]};
  // Operand as taken two edges back
  always_ff @(posedge clk) begin
    d1 <= reg_data;
    d2 <= d1;
  end
  property p_reg_timing;
    rg |-> ##1 busy ##1 (reg_we && reg_wsel == $past(reg_sel, 2))
      ##1 (done && !busy && !illegal);
  endproperty
  a_reg_timing: assert property (p_reg_timing)
    else $error("register write or done out of place");
  property p_force_one;
    go && op == SBM_OP_SINGLE_BIT_FORCE_ONE |-> ##2
      result == ($past(reg_data, 2) | (8'h01 << $past(sel, 2)));
  endproperty
  a_force_one: assert property (p_force_one)
    else $error("force one result wrong");
  property p_force_zero;
    go && op == SBM_OP_SINGLE_BIT_FORCE_ZERO |-> ##2
      result == ($past(reg_data, 2) & ~(8'h01 << $past(sel, 2)));
  endproperty
  a_force_zero: assert property (p_force_zero)
    else $error("force zero result wrong");
  property p_probe;
    go && op == SBM_OP_SINGLE_BIT_PROBE |-> ##2
      (z_we && !reg_we && z_out == !$past(sv, 2));
  endproperty
  a_probe: assert property (p_probe)
    else $error("probe zero flag wrong");
  property p_xor;
    go && op == SBM_OP_CARRY_XOR_BIT |-> ##2
      (c_we && c_out == ($past(c_in, 2) ^ $past(sv, 2)));
  endproperty
  a_xor: assert property (p_xor)
    else $error("carry xor wrong");
  property p_rot_left;
    go && op == SBM_OP_ROTATE_LEFT_PLAIN |-> ##2
      (result == {d2[6:0], d2[7]} && c_out == d2[7]);
  endproperty
  a_rot_left: assert property (p_rot_left)
    else $error("plain rotate left wrong");
  property p_asr;
    go && op == SBM_OP_ARITH_SHIFT_RIGHT |-> ##2
      (result == {d2[7], d2[7:1]} && c_out == d2[0]);
  endproperty
  a_asr: assert property (p_asr)
    else $error("arithmetic right shift wrong");
  property p_inv_reg;
    go && bitno_from_reg && op inside {SBM_OP_CARRY_AND_INVERTED_BIT,
      SBM_OP_CARRY_OR_INVERTED_BIT} |-> !c_we [*3] ##0 done && illegal;
  endproperty
  a_inv_reg: assert property (p_inv_reg)
    else $error("register bit number not refused");
  property p_mem_hold;
    mem_rd && !mem_ack |=> mem_rd;
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory read dropped before ack");
  c_reg: cover property (rg ##3 done);
  c_mem: cover property (mem_rd && mem_ack);
  c_ill: cover property (done && illegal);
endmodule // sbm_unit_checker

bind sbm_unit sbm_unit_checker u_chk (.clk, .rst_n, .start, .op, .use_iw,
  .reg_sel, .reg_data, .mem_opnd, .bitno_from_reg, .bitno_imm, .bitno_reg,
  .c_in, .busy, .done, .illegal, .result, .reg_we, .reg_wsel, .c_we,
  .c_out, .z_we, .z_out, .mem_rd, .mem_ack);

// [test/sbm_unit_test.sv]
// Self-checking bench for the shift and bit manipulation unit.
// Assumes the unit's hand-over contract: done ends each request.
module sbm_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sbm_pkg::*;
  logic clk, rst_n, start, use_iw, mem_opnd, bitno_from_reg, c_in;
  sbm_op_t op;
  logic [15:0] instr, mem_addr_in, mem_addr;
  logic [3:0] reg_sel, reg_wsel, lat;
  logic [7:0] reg_data, bitno_reg, result, mem_wdata, mem_rdata;
  logic [2:0] bitno_imm;
  logic busy, done, illegal, reg_we, c_we, c_out, z_we, z_out;
  logic mem_rd, mem_wr, mem_ack;
  int err_count = 0;
  int total_checks = 0;
  int we_n = 0;
  int cw_n = 0;
  sbm_unit uut (.clk, .rst_n, .start, .op, .instr, .use_iw, .reg_sel,
    .reg_data, .mem_opnd, .mem_addr_in, .bitno_from_reg, .bitno_imm,
    .bitno_reg, .c_in, .busy, .done, .illegal, .result, .reg_we,
    .reg_wsel, .c_we, .c_out, .z_we, .z_out, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  sbm_mem_model u_mem (.clk, .rst_n, .lat, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Write pulses seen since the counters were last cleared
  always @(negedge clk) begin
    if (reg_we === 1'b1) we_n++;
    if (c_we === 1'b1) cw_n++;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic run(sbm_op_t o, logic [7:0] d, logic c);
    int i;
    @(negedge clk);
    op = o;
    reg_data = d;
    c_in = c;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk);
    if (i == 100) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  function automatic logic [8:0] exp_sh(sbm_op_t o, logic [7:0] d,
    logic c);
    case (o)
      SBM_OP_ARITH_SHIFT_RIGHT: return {d[0], d[7], d[7:1]};
      SBM_OP_LOGIC_SHIFT_RIGHT: return {d[0], 1'b0, d[7:1]};
      SBM_OP_ROTATE_LEFT_PLAIN: return {d[7], d[6:0], d[7]};
      SBM_OP_ROTATE_RIGHT_PLAIN: return {d[0], d[0], d[7:1]};
      SBM_OP_ROTATE_LEFT_VIA_CARRY: return {d[7], d[6:0], c};
      SBM_OP_ROTATE_RIGHT_VIA_CARRY: return {d[0], c, d[7:1]};
      default: return {d, 1'b0};
    endcase
  endfunction
  task automatic t_shift();
    logic [8:0] e;
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      for (int i = 1; i <= 8; i++) begin
        d = k ? 8'h69 : 8'h96;
        mem_opnd = k[0];
        reg_sel = i[3:0];
        e = exp_sh(sbm_op_t'(i[4:0]), d, k[0]);
        we_n = 0;
        run(sbm_op_t'(i[4:0]), d, k[0]);
        chk8("shift", e[7:0], result);
        chk1("shift c", e[8], c_out);
        chk8("shift reg", {4'h0, reg_sel}, {4'h0, reg_wsel});
        chk8("shift we", 8'h01, 8'(we_n));
      end
    end
  endtask
  task automatic t_instr();
    use_iw = 1'b1;
    mem_opnd = 1'b0;
    reg_sel = 4'h0;
    instr = {SBM_OPC_RR, 4'hA};
    run(SBM_OP_NONE, 8'h81, 1'b0);
    chk8("iw rr", 8'hC0, result);
    chk8("iw reg", 8'h0A, {4'h0, reg_wsel});
    instr = {SBM_OPC_LSR, 4'h3};
    run(SBM_OP_NONE, 8'h81, 1'b0);
    chk8("iw lsr", 8'h40, result);
    chk8("iw reg", 8'h03, {4'h0, reg_wsel});
    instr = 16'hFFF5;
    run(SBM_OP_NONE, 8'h81, 1'b0);
    chk1("iw bad", 1'b1, illegal);
    use_iw = 1'b0;
  endtask
  task automatic t_bitreg();
    logic [7:0] m;
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        bitno_from_reg = s[0];
        bitno_imm = s ? 3'(~b) : 3'(b);
        bitno_reg = s ? {5'h1F, 3'(b)} : {5'h00, 3'(~b)};
        run(SBM_OP_SINGLE_BIT_FORCE_ONE, 8'h5A, 1'b0);
        chk8("set", 8'h5A | m, result);
        run(SBM_OP_SINGLE_BIT_FORCE_ZERO, 8'h5A, 1'b0);
        chk8("clear", 8'h5A & ~m, result);
        run(SBM_OP_SINGLE_BIT_INVERT, 8'h5A, 1'b0);
        chk8("invert", 8'h5A ^ m, result);
        we_n = 0;
        run(SBM_OP_SINGLE_BIT_PROBE, 8'h5A, 1'b0);
        chk1("probe z", ~|(8'h5A & m), z_out);
        chk8("probe we", 8'h00, 8'(we_n));
      end
    end
  endtask
  task automatic t_carry();
    sbm_op_t ops [5] = '{SBM_OP_CARRY_AND_BIT, SBM_OP_CARRY_AND_INVERTED_BIT,
      SBM_OP_CARRY_OR_BIT, SBM_OP_CARRY_OR_INVERTED_BIT, SBM_OP_CARRY_XOR_BIT};
    logic e, b, c;
    bitno_from_reg = 1'b0;
    bitno_imm = 3'h5;
    for (int n = 0; n < 20; n++) begin
      b = n[0];
      c = n[1];
      case (n >> 2)
        0: e = c & b;
        1: e = c & ~b;
        2: e = c | b;
        3: e = c | ~b;
        default: e = c ^ b;
      endcase
      run(ops[n >> 2], b ? 8'h20 : 8'hDF, c);
      chk1("carry", e, c_out);
    end
  endtask
  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      bitno_from_reg = 1'b1;
      bitno_reg = 8'h05;
      cw_n = 0;
      run(k ? SBM_OP_CARRY_AND_INVERTED_BIT : SBM_OP_CARRY_OR_INVERTED_BIT,
        8'h00, 1'b0);
      chk1("refused", 1'b1, illegal);
      chk8("refused c", 8'h00, 8'(cw_n));
    end
    bitno_from_reg = 1'b0;
    run(SBM_OP_CARRY_OR_INVERTED_BIT, 8'h00, 1'b0);
    chk1("imm legal", 1'b0, illegal);
    chk1("imm c", 1'b1, c_out);
  endtask
  task automatic t_mem();
    int w;
    mem_opnd = 1'b1;
    bitno_imm = 3'h1;
    mem_addr_in = 16'h0042;
    for (int l = 0; l < 4; l += 3) begin
      lat = 4'(l);
      u_mem.mem[8'h42] = 8'hF3;
      w = u_mem.wr_n;
      we_n = 0;
      run(SBM_OP_SINGLE_BIT_FORCE_ZERO, 8'h00, 1'b0);
      chk8("mem byte", 8'hF1, u_mem.mem[8'h42]);
      chk8("mem wr", 8'h01, 8'(u_mem.wr_n - w));
      chk8("mem reg we", 8'h00, 8'(we_n));
      run(SBM_OP_SINGLE_BIT_PROBE, 8'h00, 1'b0);
      chk1("mem probe", 1'b1, z_out);
      chk8("probe wr", 8'h01, 8'(u_mem.wr_n - w));
    end
  endtask
  initial begin
    {rst_n, start, use_iw, mem_opnd, bitno_from_reg, c_in} = 6'h00;
    op = SBM_OP_NONE;
    instr = 16'h0000;
    mem_addr_in = 16'h0000;
    reg_sel = 4'h0;
    lat = 4'h0;
    reg_data = 8'h00;
    bitno_reg = 8'h00;
    bitno_imm = 3'h0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_shift();
    t_instr();
    t_bitreg();
    t_carry();
    t_refuse();
    t_mem();
    tally_and_finish();
  end
endmodule // sbm_unit_test
